// ==== bench/lcsu_fetch_model.sv ====
// Operand fetch side: shows fetched words only while offered.
// Assumes valid rises with the unit's start.
`timescale 1ns/1ps

module lcsu_fetch_model (
  // Clock
  input  wire        clk,
  // Offer from the bench
  input  wire        valid,
  input  wire [31:0] cm_in,
  input  wire [31:0] cr_in,
  // Words to the unit
  output wire [31:0] cm_word,
  output wire [31:0] cr_word
);
  reg [31:0] cm_junk_r = 32'h5A5A5A5A;
  reg [31:0] cr_junk_r = 32'hA5A5A5A5;

  // Stale words change every cycle so late sampling shows up
  always @(posedge clk) begin
    cm_junk_r <= ~cm_word;
    cr_junk_r <= ~cr_word;
  end
  assign cm_word = valid ? cm_in : cm_junk_r;
  assign cr_word = valid ? cr_in : cr_junk_r;
endmodule

// ==== bench/lcsu_unit_assertions.sv ====
// Port checker for the logic and skip unit.
// Assumes binding to the unit's top; sees only its ports.
`timescale 1ns/1ps
`include "lcsu_map.vh"

module lcsu_unit_assertions (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Request
  input wire logic                  start,
  input wire logic [7:0]            opcode,
  input wire logic [`LCSU_PC_W-1:0] pc_in,
  // Completion
  input wire logic                  busy,
  input wire logic                  done_r,
  input wire logic                  skip_r,
  input wire logic                  illegal_r,
  input wire logic [`LCSU_PC_W-1:0] pc_out_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Upper nibble kept so its history can be sampled
  wire [3:0] op_hi = opcode[7:4];

  // Idle unit takes a request
  sequence s_take;
    start && !busy;
  endsequence
  // Result two edges later
  sequence s_finish;
    ##2 done_r;
  endsequence

  done_time_a: assert property (s_take |-> s_finish)
    else $error("done late");
  busy_window_a: assert property (s_take |=> busy ##1 !busy)
    else $error("busy window wrong");
  done_pulse_a: assert property (done_r |=> !done_r)
    else $error("done too long");
  skip_pc_a: assert property (done_r && skip_r |->
    pc_out_r == $past(pc_in, 2) + `LCSU_PC_SKIP) else $error("skip pc");
  step_pc_a: assert property (done_r && !skip_r |->
    pc_out_r == $past(pc_in, 2) + `LCSU_PC_STEP) else $error("step pc");
  logic_noskip_a: assert property (s_take ##0
    (op_hi == 4'h4 && opcode[1:0] != 2'h2) |-> ##2
    (done_r && !skip_r && !illegal_r)) else $error("logic op skipped");
  skip_origin_a: assert property (done_r && skip_r |->
    $past(op_hi, 2) inside {4'h3, 4'hD, 4'hF}) else $error("odd skip");
  pc_hold_a: assert property (!done_r && $past(rst_n) |->
    $stable(pc_out_r)) else $error("pc moved");
  illegal_flag_a: assert property (done_r && illegal_r |->
    !skip_r) else $error("illegal skipped");
endmodule

// ==== bench/test_lcsu_unit.sv ====
// Random bench for the logic and skip unit, every opcode tried.
// Assumes a 10 MHz clock and the two-edge answer of the unit.
`timescale 1ns/1ps
`include "lcsu_map.vh"

module test_lcsu_unit;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         start = 1'b0;
  reg  [7:0]  opcode = 8'h00;
  reg  [3:0]  rf = 4'h0;
  reg  [1:0]  rp = 2'h0;
  reg  [3:0]  nf = 4'h0;
  reg  [1:0]  np = 2'h0;
  reg  [23:0] pc = 24'h000000;
  reg  [31:0] cm = 32'h00000000;
  reg  [31:0] cr = 32'h00000000;
  reg         we = 1'b0;
  reg  [3:0]  widx = 4'h0;
  reg  [31:0] wdat = 32'h00000000;
  wire [31:0] cm_w;
  wire [31:0] cr_w;
  wire [31:0] rd;
  wire        busy;
  wire        done;
  wire        skip;
  wire        ill;
  wire [23:0] pco;
  reg  [31:0] mdl [0:15];
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     i;

  always #50 clk = ~clk;

  lcsu_fetch_model fetch (.clk(clk), .valid(start), .cm_in(cm),
    .cr_in(cr), .cm_word(cm_w), .cr_word(cr_w));
  lcsu_unit dut (.clk(clk), .rst_n(rst_n), .start(start),
    .opcode(opcode), .r_field(rf), .r_part(rp), .n_field(nf),
    .n_part(np), .pc_in(pc), .cm_word(cm_w), .cr_word(cr_w),
    .vpr_wr_en(we), .vpr_wr_idx(widx), .vpr_wr_data(wdat),
    .vpr_rd_idx(rf), .vpr_rd_data_r(rd), .busy(busy), .done_r(done),
    .skip_r(skip), .illegal_r(ill), .pc_out_r(pco));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Own decode: legal, function, width, source
  function [8:0] dec(input [7:0] op);
    reg [2:0] hb;
    begin
      hb = (op[1:0] == 2'h0) ? 3'h0 : (op[1:0] == 2'h1) ? 3'h1 : 3'h2;
      dec = 9'h000;
      if (op[1:0] != 2'h2)
        case (op[7:4])
          4'h4: dec = {2'b10, op[3:2], hb + {hb != 3'h0, 1'b0}, 2'h0};
          4'hC, 4'hE: dec = {2'b10, op[3:2], hb, op[5], !op[5]};
          4'h3: if (!op[3])
            dec = {3'b110, op[2], hb + {hb != 3'h0, 1'b0}, 2'h0};
          4'hD, 4'hF: if (op[3]) dec = {3'b110, op[2], hb, op[5], !op[5]};
          default: dec = 9'h000;
        endcase
    end
  endfunction

  task wr(input [3:0] idx, input [31:0] v);
    begin
      @(posedge clk) #1;
      we = 1'b1;
      widx = idx;
      wdat = v;
      @(posedge clk) #1;
      we = 1'b0;
      mdl[idx] = v;
    end
  endtask

  task run(input [7:0] op, input hitm);
    reg [8:0]  d;
    reg [31:0] sw, t, o, m, r;
    reg        s;
    integer    k;
    begin
      d = dec(op);
      @(posedge clk) #1;
      {rf, rp, nf, np} = 12'($urandom);
      pc = 24'($urandom);
      cm = $urandom;
      cr = $urandom;
      t = mdl[rf];
      if (hitm) {nf, np, cm, cr} = {rf, rp, t, t};
      start = 1'b1;
      opcode = op;
      sw = (d[1:0] == 2'h0) ? cm : (d[1:0] == 2'h1) ? mdl[nf] : cr;
      k = (d[4:2] == 3'h3) ? 16 : (d[4:2] == 3'h4) ? 0 : 16 - 16 * np[1];
      m = 32'h0000FFFF << (16 - 16 * rp[1]);
      o = ((sw >> k) & 32'h0000FFFF) << (16 - 16 * rp[1]);
      if (d[4:2] == 3'h2) begin
        m = 32'h000000FF << (8 * (3 - rp));
        o = ((sw >> (8 * (3 - np))) & 32'h000000FF) << (8 * (3 - rp));
      end
      if (d[4:2] == 3'h0) {m, o} = {32'hFFFFFFFF, sw};
      case (d[7:5])
        3'h0: r = t & o;
        3'h1: r = t | o;
        3'h2: r = ~(t ^ o);
        default: r = t ^ o;
      endcase
      r = (t & ~m) | (r & m);
      s = d[7] && ((((t ^ o) & m) == 32'h0) ^ d[5]);
      if (d[7] || !d[8]) r = t;
      @(posedge clk) #1;
      start = 1'b0;
      // Side write while busy must be dropped
      {we, widx, wdat} = {1'b1, rf, ~r};
      check(busy, 1'b1);
      @(posedge clk) #1;
      we = 1'b0;
      check(done, 1'b1);
      check(skip, s);
      check(ill, !d[8]);
      // Counter wraps at 24 bits, so cut the sum before the compare
      check(24'(pc + (s ? 24'h000002 : 24'h000001)), pco);
      mdl[rf] = r;
      @(posedge clk) #1;
      check(rd, r);
    end
  endtask

  // Main sequence: reset, load registers, sweep all opcodes thrice
  initial begin
    i = $urandom(32'hC776);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    check(done, 1'b0);
    check(pco, 24'h000000);
    for (i = 0; i < 16; i = i + 1)
      wr(i[3:0], $urandom);
    for (i = 0; i < 768; i = i + 1)
      run(i[7:0], 1'($urandom));
    finish_test;
  end

  // Watchdog well past the expected run length
  initial begin
    #(5000 * 100);
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule

bind lcsu_unit lcsu_unit_assertions chk (.clk(clk), .rst_n(rst_n),
  .start(start), .opcode(opcode), .pc_in(pc_in), .busy(busy),
  .done_r(done_r), .skip_r(skip_r), .illegal_r(illegal_r),
  .pc_out_r(pc_out_r));

// ==== logic/lcsu_alu.v ====
// Bitwise combine and lane compare for the logic and skip unit.
// Assumes the operand is already placed in the target lane and the
// lane mask marks the bits that the instruction owns.
`timescale 1ns/1ps
`include "lcsu_map.vh"

module lcsu_alu (
  // Control
  input  wire [2:0]  func,
  // Data
  input  wire [31:0] tgt,
  input  wire [31:0] opnd,
  input  wire [31:0] lane_mask,
  // Results
  output reg  [31:0] merged,
  output wire        lane_equal
);

  reg [31:0] raw;

  // ----------------------------------------------------------------
  // Function select and lane merge
  // ----------------------------------------------------------------
  // Bits outside the lane always keep the old register value
  always @* begin
    case (func)
      `LCSU_FN_AND:  raw = tgt & opnd;
      `LCSU_FN_OR:   raw = tgt | opnd;
      `LCSU_FN_XOR:  raw = tgt ^ opnd;
      `LCSU_FN_XNOR: raw = ~(tgt ^ opnd);
      default:       raw = tgt;  // Compares never alter the register
    endcase
    merged = (tgt & ~lane_mask) | (raw & lane_mask);
  end

  // Equality looks only at the owned lane
  assign lane_equal = (((tgt ^ opnd) & lane_mask) == 32'h00000000);

endmodule

// ==== logic/lcsu_map.vh ====
// Constants for the logic and compare-and-skip unit: opcodes, decode
// fields, widths and program counter steps.
// Assumes inclusion by bare name from every file of the unit.
`ifndef LCSU_MAP_VH
`define LCSU_MAP_VH

// ----------------------------------------------------------------
// Data path sizes
// ----------------------------------------------------------------
`define LCSU_VPR_CNT      16
`define LCSU_PC_W         24
`define LCSU_PC_STEP      24'h000001
`define LCSU_PC_SKIP      24'h000002

// ----------------------------------------------------------------
// Decoded function, width and source codes
// ----------------------------------------------------------------
`define LCSU_FN_AND       3'h0
`define LCSU_FN_OR        3'h1
`define LCSU_FN_XOR       3'h2
`define LCSU_FN_XNOR      3'h3
`define LCSU_FN_CEQ       3'h4
`define LCSU_FN_CNE       3'h5
`define LCSU_W_WORD       3'h0
`define LCSU_W_HALF       3'h1
`define LCSU_W_BYTE       3'h2
`define LCSU_W_UPPER      3'h3
`define LCSU_W_LOWER      3'h4
`define LCSU_SRC_CM       2'h0
`define LCSU_SRC_VPR      2'h1
`define LCSU_SRC_CR       2'h2

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define LCSU_OP_OR_W_CM   8'h44
`define LCSU_OP_OR_W_VPR  8'hC4
`define LCSU_OP_OR_W_CR   8'hE4
`define LCSU_OP_OR_H_VPR  8'hC5
`define LCSU_OP_OR_H_CR   8'hE5
`define LCSU_OP_OR_B_VPR  8'hC7
`define LCSU_OP_OR_B_CR   8'hE7
`define LCSU_OP_OR_UP     8'h45
`define LCSU_OP_OR_LO     8'h47
`define LCSU_OP_AND_W_CM  8'h40
`define LCSU_OP_AND_W_VPR 8'hC0
`define LCSU_OP_AND_W_CR  8'hE0
`define LCSU_OP_AND_H_VPR 8'hC1
`define LCSU_OP_AND_H_CR  8'hE1
`define LCSU_OP_AND_B_VPR 8'hC3
`define LCSU_OP_AND_B_CR  8'hE3
`define LCSU_OP_AND_UP    8'h41
`define LCSU_OP_AND_LO    8'h43
`define LCSU_OP_XOR_W_CM  8'h4C
`define LCSU_OP_XOR_W_VPR 8'hCC
`define LCSU_OP_XOR_W_CR  8'hEC
`define LCSU_OP_XOR_H_VPR 8'hCD
`define LCSU_OP_XOR_H_CR  8'hED
`define LCSU_OP_XOR_B_VPR 8'hCF
`define LCSU_OP_XOR_B_CR  8'hEF
`define LCSU_OP_XOR_UP    8'h4D
`define LCSU_OP_XOR_LO    8'h4F
`define LCSU_OP_EQV_W_CM  8'h48
`define LCSU_OP_EQV_W_VPR 8'hC8
`define LCSU_OP_EQV_W_CR  8'hE8
`define LCSU_OP_EQV_H_VPR 8'hC9
`define LCSU_OP_EQV_H_CR  8'hE9
`define LCSU_OP_EQV_B_VPR 8'hCB
`define LCSU_OP_EQV_B_CR  8'hEB
`define LCSU_OP_EQV_UP    8'h49
`define LCSU_OP_EQV_LO    8'h4B
`define LCSU_OP_CEQ_W_CM  8'h30
`define LCSU_OP_CEQ_W_VPR 8'hD8
`define LCSU_OP_CEQ_W_CR  8'hF8
`define LCSU_OP_CEQ_H_VPR 8'hD9
`define LCSU_OP_CEQ_H_CR  8'hF9
`define LCSU_OP_CEQ_B_VPR 8'hDB
`define LCSU_OP_CEQ_B_CR  8'hFB
`define LCSU_OP_CEQ_UP    8'h31
`define LCSU_OP_CEQ_LO    8'h33
`define LCSU_OP_CNE_W_CM  8'h34
`define LCSU_OP_CNE_W_VPR 8'hDC
`define LCSU_OP_CNE_W_CR  8'hFC
`define LCSU_OP_CNE_H_VPR 8'hDD
`define LCSU_OP_CNE_H_CR  8'hFD
`define LCSU_OP_CNE_B_VPR 8'hDF
`define LCSU_OP_CNE_B_CR  8'hFF
`define LCSU_OP_CNE_UP    8'h35
`define LCSU_OP_CNE_LO    8'h37

`endif

// ==== logic/lcsu_unit.v ====
// Logic and compare-and-skip execution unit with its own register file.
// Assumes decode hands over one instruction at a time with the memory
// and communication register operands already fetched.
`timescale 1ns/1ps
`include "lcsu_map.vh"

module lcsu_unit (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst_n,
  // Instruction hand-over
  input  wire                  start,
  input  wire [7:0]            opcode,
  input  wire [3:0]            r_field,
  input  wire [1:0]            r_part,
  input  wire [3:0]            n_field,
  input  wire [1:0]            n_part,
  input  wire [`LCSU_PC_W-1:0] pc_in,
  // Fetched operands
  input  wire [31:0]           cm_word,
  input  wire [31:0]           cr_word,
  // Register file side port
  input  wire                  vpr_wr_en,
  input  wire [3:0]            vpr_wr_idx,
  input  wire [31:0]           vpr_wr_data,
  input  wire [3:0]            vpr_rd_idx,
  output reg  [31:0]           vpr_rd_data_r,
  // Completion
  output wire                  busy,
  output reg                   done_r,
  output reg                   skip_r,
  output reg                   illegal_r,
  output reg  [`LCSU_PC_W-1:0] pc_out_r
);

  // ----------------------------------------------------------------
  // States and storage
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0]            state_r;
  reg [1:0]            state_nxt;
  reg [31:0]           vpr_r [0:`LCSU_VPR_CNT-1];
  reg [7:0]            op_r;
  reg [3:0]            rf_r;
  reg [1:0]            rp_r;
  reg [3:0]            nf_r;
  reg [1:0]            np_r;
  reg [`LCSU_PC_W-1:0] pc_r;
  reg [31:0]           cm_r;
  reg [31:0]           cr_r;
  integer              i;

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  // Bring the addressed lane down to the low bits; part 0 is leftmost
  function [31:0] lcsu_extract;
    input [31:0] word;
    input [2:0]  wd;
    input [1:0]  part;
    begin
      case (wd)
        `LCSU_W_UPPER: lcsu_extract = {16'h0000, word[31:16]};
        `LCSU_W_LOWER: lcsu_extract = {16'h0000, word[15:0]};
        `LCSU_W_HALF: begin
          if (part[1])
            lcsu_extract = {16'h0000, word[15:0]};
          else
            lcsu_extract = {16'h0000, word[31:16]};
        end
        `LCSU_W_BYTE: begin
          case (part)
            2'h0:    lcsu_extract = {24'h000000, word[31:24]};
            2'h1:    lcsu_extract = {24'h000000, word[23:16]};
            2'h2:    lcsu_extract = {24'h000000, word[15:8]};
            default: lcsu_extract = {24'h000000, word[7:0]};
          endcase
        end
        default: lcsu_extract = word;
      endcase
    end
  endfunction

  // Place a low-aligned value into the target register lane
  function [31:0] lcsu_place;
    input [31:0] val;
    input [2:0]  wd;
    input [1:0]  part;
    begin
      case (wd)
        `LCSU_W_HALF, `LCSU_W_UPPER, `LCSU_W_LOWER: begin
          if (part[1])
            lcsu_place = {16'h0000, val[15:0]};
          else
            lcsu_place = {val[15:0], 16'h0000};
        end
        `LCSU_W_BYTE: begin
          case (part)
            2'h0:    lcsu_place = {val[7:0], 24'h000000};
            2'h1:    lcsu_place = {8'h00, val[7:0], 16'h0000};
            2'h2:    lcsu_place = {16'h0000, val[7:0], 8'h00};
            default: lcsu_place = {24'h000000, val[7:0]};
          endcase
        end
        default: lcsu_place = val;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Opcode decode: {valid, source, width, function}
  // ----------------------------------------------------------------
  function [8:0] lcsu_decode;
    input [7:0] op;
    begin
      case (op)
        `LCSU_OP_OR_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_OR};
        `LCSU_OP_OR_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_OR};
        `LCSU_OP_OR_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_OR};
        `LCSU_OP_OR_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_OR};
        `LCSU_OP_OR_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_OR};
        `LCSU_OP_OR_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_OR};
        `LCSU_OP_OR_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_OR};
        `LCSU_OP_OR_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_OR};
        `LCSU_OP_OR_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_OR};
        `LCSU_OP_AND_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_AND};
        `LCSU_OP_AND_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_AND};
        `LCSU_OP_AND_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_AND};
        `LCSU_OP_AND_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_AND};
        `LCSU_OP_AND_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_AND};
        `LCSU_OP_AND_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_AND};
        `LCSU_OP_AND_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_AND};
        `LCSU_OP_AND_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_AND};
        `LCSU_OP_AND_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_AND};
        `LCSU_OP_XOR_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_XOR};
        `LCSU_OP_XOR_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_XOR};
        `LCSU_OP_XOR_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_XOR};
        `LCSU_OP_XOR_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_XOR};
        `LCSU_OP_XOR_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_XOR};
        `LCSU_OP_XOR_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_XOR};
        `LCSU_OP_XOR_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_XOR};
        `LCSU_OP_XOR_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_XOR};
        `LCSU_OP_XOR_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_XOR};
        `LCSU_OP_EQV_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_XNOR};
        `LCSU_OP_EQV_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_XNOR};
        `LCSU_OP_CEQ_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_CEQ};
        `LCSU_OP_CEQ_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_CEQ};
        `LCSU_OP_CNE_W_CM:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_WORD, `LCSU_FN_CNE};
        `LCSU_OP_CNE_W_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_WORD, `LCSU_FN_CNE};
        `LCSU_OP_CNE_W_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_WORD, `LCSU_FN_CNE};
        `LCSU_OP_CNE_H_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_HALF, `LCSU_FN_CNE};
        `LCSU_OP_CNE_H_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_HALF, `LCSU_FN_CNE};
        `LCSU_OP_CNE_B_VPR:
          lcsu_decode = {1'b1, `LCSU_SRC_VPR, `LCSU_W_BYTE, `LCSU_FN_CNE};
        `LCSU_OP_CNE_B_CR:
          lcsu_decode = {1'b1, `LCSU_SRC_CR, `LCSU_W_BYTE, `LCSU_FN_CNE};
        `LCSU_OP_CNE_UP:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_UPPER, `LCSU_FN_CNE};
        `LCSU_OP_CNE_LO:
          lcsu_decode = {1'b1, `LCSU_SRC_CM, `LCSU_W_LOWER, `LCSU_FN_CNE};
        default:
          lcsu_decode = 9'h000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Operand steering
  // ----------------------------------------------------------------
  wire [8:0]  dec       = lcsu_decode(op_r);
  wire        dec_ok    = dec[8];
  wire [1:0]  dec_src   = dec[7:6];
  wire [2:0]  dec_wd    = dec[5:3];
  wire [2:0]  dec_fn    = dec[2:0];
  wire [31:0] tgt_word  = vpr_r[rf_r];
  wire [31:0] lane_mask;
  wire [31:0] opnd_al;
  wire [31:0] merged;
  wire        lane_equal;
  reg  [31:0] src_word;

  // Source pick; the register source is read at execute time
  always @* begin
    case (dec_src)
      `LCSU_SRC_VPR: src_word = vpr_r[nf_r];
      `LCSU_SRC_CR:  src_word = cr_r;
      default:       src_word = cm_r;
    endcase
  end

  // Align the operand lane to the target lane of the register
  assign opnd_al   = lcsu_place(lcsu_extract(src_word, dec_wd, np_r),
                                dec_wd, rp_r);
  assign lane_mask = lcsu_place(lcsu_extract(32'hFFFFFFFF, dec_wd, 2'h0),
                                dec_wd, rp_r);

  lcsu_alu u_alu (
    .func       (dec_fn),
    .tgt        (tgt_word),
    .opnd       (opnd_al),
    .lane_mask  (lane_mask),
    .merged     (merged),
    .lane_equal (lane_equal)
  );

  // ----------------------------------------------------------------
  // Sequencer and write-back
  // ----------------------------------------------------------------
  wire is_cmp   = (dec_fn == `LCSU_FN_CEQ) || (dec_fn == `LCSU_FN_CNE);
  wire skip_hit = dec_ok &&
                  (((dec_fn == `LCSU_FN_CEQ) && lane_equal) ||
                   ((dec_fn == `LCSU_FN_CNE) && !lane_equal));

  assign busy = (state_r == ST_EXEC);

  // One cycle to capture, one to execute
  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = start ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Side-port writes only land while idle, so no write-back is lost
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      op_r      <= 8'h00;
      rf_r      <= 4'h0;
      rp_r      <= 2'h0;
      nf_r      <= 4'h0;
      np_r      <= 2'h0;
      pc_r      <= {`LCSU_PC_W{1'b0}};
      cm_r      <= 32'h00000000;
      cr_r      <= 32'h00000000;
      done_r    <= 1'b0;
      skip_r    <= 1'b0;
      illegal_r <= 1'b0;
      pc_out_r  <= {`LCSU_PC_W{1'b0}};
      for (i = 0; i < `LCSU_VPR_CNT; i = i + 1)
        vpr_r[i] <= 32'h00000000;
    end else begin
      state_r   <= state_nxt;
      done_r    <= 1'b0;
      skip_r    <= 1'b0;
      illegal_r <= 1'b0;
      if (state_r == ST_IDLE && start) begin
        op_r <= opcode;
        rf_r <= r_field;
        rp_r <= r_part;
        nf_r <= n_field;
        np_r <= n_part;
        pc_r <= pc_in;
        cm_r <= cm_word;
        cr_r <= cr_word;
      end else if (state_r == ST_IDLE && vpr_wr_en) begin
        vpr_r[vpr_wr_idx] <= vpr_wr_data;
      end
      if (state_r == ST_EXEC) begin
        done_r    <= 1'b1;
        illegal_r <= !dec_ok;
        skip_r    <= skip_hit;
        if (skip_hit)
          pc_out_r <= pc_r + `LCSU_PC_SKIP;
        else
          pc_out_r <= pc_r + `LCSU_PC_STEP;
        if (dec_ok && !is_cmp)
          vpr_r[rf_r] <= merged;
      end
    end
  end

  // Registered observation port
  always @(posedge clk) begin
    if (!rst_n)
      vpr_rd_data_r <= 32'h00000000;
    else
      vpr_rd_data_r <= vpr_r[vpr_rd_idx];
  end

endmodule
